//--- logic/baf_burst_framer.sv
// Purpose: Address filtering, block kind handling and host data words for a 4FSK framer
// Assumes: Demodulator and host logic run on the same clock; one block per pulse
// Notes:   Host reads are registered, so read data lags the index by one cycle
`timescale 1ns/100ps
module baf_burst_framer
  import baf_pkg::*;
#(
  parameter logic [SYNC_W-1:0] NORMAL_SYNC = 24'h0000_00
)
(
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                reset_n,
  // Configuration
  input  wire logic [WORD_W-1:0]   modem_config,
  input  wire logic [ID_W-1:0]     local_identity_a,
  input  wire logic [ID_W-1:0]     local_identity_b,
  input  wire logic                payload_type2,
  // Host data word port
  input  wire logic                host_write,
  input  wire logic [2:0]          host_write_index,
  input  wire logic [WORD_W-1:0]   host_write_data,
  input  wire logic                host_read_rx,
  input  wire logic [2:0]          host_read_index,
  output logic [WORD_W-1:0]        host_read_data,
  // Demodulator side
  input  wire logic                rx_sync_valid,
  input  wire logic [SYNC_W-1:0]   rx_sync_word,
  input  wire logic                rx_block_valid,
  input  wire logic [1:0]          rx_block_kind,
  input  wire baf_block_type       rx_block,
  // Receive status
  output logic                     rx_data_ready,
  output logic                     rx_burst_rejected,
  output logic                     packet_burst,
  output baf_size_type             rx_block_size,
  // Transmit side
  output logic                     tx_block_valid,
  output baf_block_type            tx_block,
  output baf_size_type             tx_block_size,
  output logic                     tx_sequence_error,
  output logic                     tx_size_error,
  output logic                     beacon_channel
);

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_HEADER  = 5'b00010,
    ST_TRAFFIC = 5'b00100,
    ST_PACKET  = 5'b01000,
    ST_DISCARD = 5'b10000
  } baf_state_type;

  baf_state_type state_reg, state_next;
  baf_block_type tx_words_reg, rx_words_reg;
  logic [1:0]    rx_count_reg;
  logic [7:0]    blocks_left_reg, blocks_left_next;
  logic          packet_reg, packet_next;
  logic          rx_write_next, reject_next;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration decode
  wire logic check_enable = modem_config[CFG_ADDR_CHECK_BIT];
  wire logic bcd_mode     = modem_config[CFG_BCD_BIT];
  wire logic beacon_mode  = modem_config[CFG_BEACON_BIT];

  // Sync classification; anything else is not a burst start
  wire logic sync_normal = rx_sync_valid && rx_sync_word == NORMAL_SYNC;
  wire logic sync_packet = rx_sync_valid && rx_sync_word == ~NORMAL_SYNC;

  // Header field extraction
  wire logic [ID_W-1:0] destination_identity = {rx_block.w0[CALLED_HI_LSB +: 4],
                                                rx_block.w1,
                                                rx_block.w2[CALLED_LO_LSB +: 4]};
  wire logic [1:0] comm_format          = rx_block.w4[COMM_FORMAT_LSB +: 2];
  wire logic [3:0] packet_length_code   = rx_block.w4[LENGTH_CODE_LSB +: 4];
  wire logic [3:0] packets_per_burst_code = rx_block.w4[PACKETS_CODE_LSB +: 4];

  ////////////////////////////////////////////////////////////////////////////
  // Identity comparison against both local identities
  logic [1:0]           id_match;

  generate
    for (genvar g = 0; g < 2; g++) begin : gen_match
      baf_identity_match u_match (
        .local_identity       (g == 0 ? local_identity_a : local_identity_b),
        .destination_identity (destination_identity),
        .bcd_mode             (bcd_mode),
        .match                (id_match[g])
      );
    end
  endgenerate

  wire logic call_all       = comm_format == FORMAT_CALL_ALL;
  wire logic address_ok     = call_all || !check_enable || (|id_match);
  wire logic length_ok      = packet_length_code == LENGTH_CODE_288 ||
                              packet_length_code == LENGTH_CODE_1440;
  wire logic [7:0] per_packet = packet_length_code == LENGTH_CODE_1440 ? BLOCKS_1440
                                                                        : BLOCKS_288;
  wire logic [7:0] packet_blocks = 8'(per_packet * ({4'h0, packets_per_burst_code} + 8'h01));

  ////////////////////////////////////////////////////////////////////////////
  // Receive burst sequencing
  always_comb begin
    state_next       = state_reg;
    blocks_left_next = blocks_left_reg;
    packet_next      = packet_reg;
    rx_write_next    = 1'b0;
    reject_next      = 1'b0;
    if (sync_normal || sync_packet) begin
      state_next  = ST_HEADER;
      packet_next = sync_packet;
    end else if (rx_block_valid) begin
      unique case (state_reg)
        ST_IDLE, ST_DISCARD: begin
          // Blocks outside an accepted burst never reach the host
        end
        ST_HEADER: begin
          if (rx_block_kind != BLK_HEADER) begin
            state_next = ST_DISCARD;
          end else if (address_ok && (!packet_reg || length_ok)) begin
            rx_write_next    = 1'b1;
            blocks_left_next = packet_blocks;
            state_next       = packet_reg ? ST_PACKET : ST_TRAFFIC;
          end else begin
            reject_next = 1'b1;
            state_next  = ST_DISCARD;
          end
        end
        ST_TRAFFIC: begin
          rx_write_next = 1'b1;
          if (rx_block_kind == BLK_END) begin
            state_next = ST_IDLE;
          end
        end
        ST_PACKET: begin
          // Header control fields are ignored here; only the packet framing counts
          if (rx_block_kind == BLK_END) begin
            rx_write_next = 1'b1;
            state_next    = ST_IDLE;
          end else if (rx_block_kind == BLK_PAYLOAD) begin
            if (blocks_left_reg != 8'h00) begin
              rx_write_next    = 1'b1;
              blocks_left_next = blocks_left_reg - 8'h01;
            end
          end else begin
            rx_write_next = 1'b1;
          end
        end
        default: state_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg       <= ST_IDLE;
      blocks_left_reg <= 8'h00;
      packet_reg      <= 1'b0;
    end else begin
      state_reg       <= state_next;
      blocks_left_reg <= blocks_left_next;
      packet_reg      <= packet_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive data words; counter advances on every device write
  wire logic [1:0] rx_count_next = rx_count_reg + 2'h1;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_words_reg      <= '0;
      rx_count_reg      <= 2'h0;
      rx_data_ready     <= 1'b0;
      rx_burst_rejected <= 1'b0;
      rx_block_size     <= '0;
    end else begin
      rx_data_ready     <= rx_write_next;
      rx_burst_rejected <= reject_next;
      if (rx_write_next) begin
        rx_count_reg  <= rx_count_next;
        rx_words_reg  <= rx_block;
        rx_words_reg.w0[TCOUNT_LSB +: 2] <= rx_count_next;
        rx_words_reg.w0[KIND_LSB +: 2]   <= rx_block_kind;
        rx_block_size <= baf_block_size(rx_block_kind, beacon_mode, payload_type2);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit data words; a counter change in word zero marks a new block
  wire logic       tx_word0_write = host_write && host_write_index == 3'h0;
  wire logic [1:0] tx_count_old   = tx_words_reg.w0[TCOUNT_LSB +: 2];
  wire logic [1:0] tx_count_new   = host_write_data[TCOUNT_LSB +: 2];
  wire logic [1:0] tx_kind_new    = host_write_data[KIND_LSB +: 2];
  wire logic [3:0] tx_bytes_new   = host_write_data[BYTES_LSB +: 4];
  wire logic       tx_new_block   = tx_word0_write && tx_count_new != tx_count_old;
  wire logic [3:0] payload_unit   = payload_type2 ? PAYLOAD_BYTES_TYPE2 : PAYLOAD_BYTES;
  wire logic       tx_bad_size    = !beacon_mode && tx_kind_new == BLK_PAYLOAD &&
                                    tx_bytes_new != payload_unit;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_words_reg <= '0;
    end else if (host_write) begin
      unique case (host_write_index)
        3'h0:    tx_words_reg.w0 <= host_write_data;
        3'h1:    tx_words_reg.w1 <= host_write_data;
        3'h2:    tx_words_reg.w2 <= host_write_data;
        3'h3:    tx_words_reg.w3 <= host_write_data;
        3'h4:    tx_words_reg.w4 <= host_write_data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_block_valid    <= 1'b0;
      tx_block          <= '0;
      tx_block_size     <= '0;
      tx_sequence_error <= 1'b0;
      tx_size_error     <= 1'b0;
    end else begin
      tx_block_valid    <= tx_new_block;
      tx_sequence_error <= tx_new_block && tx_count_new != tx_count_old + 2'h1;
      tx_size_error     <= tx_new_block && tx_bad_size;
      if (tx_new_block) begin
        tx_block    <= tx_words_reg;
        tx_block.w0 <= host_write_data;
        tx_block_size <= baf_block_size(tx_kind_new, beacon_mode, payload_type2);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host read path and status levels
  wire baf_block_type read_words = host_read_rx ? rx_words_reg : tx_words_reg;
  wire logic [WORD_W-1:0] read_word = host_read_index == 3'h0 ? read_words.w0 :
                                      host_read_index == 3'h1 ? read_words.w1 :
                                      host_read_index == 3'h2 ? read_words.w2 :
                                      host_read_index == 3'h3 ? read_words.w3 :
                                      host_read_index == 3'h4 ? read_words.w4 : RESET_WORD;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      host_read_data <= RESET_WORD;
      packet_burst   <= 1'b0;
      beacon_channel <= 1'b0;
    end else begin
      host_read_data <= read_word;
      packet_burst   <= packet_next && state_next != ST_IDLE;
      beacon_channel <= beacon_mode;
    end
  end

endmodule : baf_burst_framer

//--- logic/baf_identity_match.sv
// Purpose: Compares one local identity with a received destination identity
// Assumes: Pure combinational; caller feeds the result into its next-state logic
// Notes:   In decimal mode any nonzero eighth digit marks a wildcard address
`timescale 1ns/100ps
module baf_identity_match
  import baf_pkg::*;
(
  // Identities
  input  wire logic [ID_W-1:0] local_identity,
  input  wire logic [ID_W-1:0] destination_identity,
  // Mode
  input  wire logic            bcd_mode,
  // Result
  output logic                 match
);

  wire logic [BCD_W-1:0] own_digits  = baf_to_bcd(local_identity);
  wire logic [BCD_W-1:0] dest_digits = baf_to_bcd(destination_identity);
  wire logic [3:0]       wild_count  = dest_digits[27:24];
  wire logic             wild_form   = dest_digits[31:28] != 4'h0;
  // Lowest one to four digits wild, or six for the ten all-call forms
  wire logic             wild_legal  = (wild_count >= 4'h1 && wild_count <= 4'h4) ||
                                       wild_count == 4'h6;
  logic                  digits_equal;

  always_comb begin
    digits_equal = 1'b1;
    for (int k = 0; k < BCD_DIGITS; k++) begin
      if (!wild_form) begin
        if (own_digits[4*k +: 4] != dest_digits[4*k +: 4]) begin
          digits_equal = 1'b0;
        end
      end else if (k >= int'(wild_count)) begin
        if (own_digits[4*k +: 4] != dest_digits[4*(k - int'(wild_count)) +: 4]) begin
          digits_equal = 1'b0;
        end
      end
    end
  end

  assign match = bcd_mode ? (digits_equal && (!wild_form || wild_legal))
                          : (local_identity == destination_identity);

endmodule : baf_identity_match

//--- logic/baf_pkg.sv
// Purpose: Shared constants, types and decoders for the burst address and block format logic
// Assumes: One 100 MHz clock; host data words are 16 bits wide
// Notes:   Header field positions follow the over-air packing of the header block
package baf_pkg;

  localparam int WORD_W     = 16;
  localparam int ID_W       = 24;
  localparam int BCD_W      = 32;
  localparam int BCD_DIGITS = 7;
  localparam int SYNC_W     = 24;

  // Modem configuration bit positions
  localparam int CFG_ADDR_CHECK_BIT = 10;
  localparam int CFG_BCD_BIT        = 11;
  localparam int CFG_BEACON_BIT     = 12;

  // Low byte of data word zero
  localparam int TCOUNT_LSB = 6;
  localparam int KIND_LSB   = 4;
  localparam int BYTES_LSB  = 0;

  // Header fields
  localparam int CALLED_HI_LSB    = 8;
  localparam int CALLED_LO_LSB    = 12;
  localparam int COMM_MODE_LSB    = 1;
  localparam int COMM_FORMAT_LSB  = 13;
  localparam int INFO_TYPE_LSB    = 8;
  localparam int LENGTH_CODE_LSB  = 4;
  localparam int PACKETS_CODE_LSB = 0;

  localparam logic [1:0] FORMAT_PEER     = 2'h0;
  localparam logic [1:0] FORMAT_CALL_ALL = 2'h1;
  localparam logic [3:0] LENGTH_CODE_288  = 4'h0;
  localparam logic [3:0] LENGTH_CODE_1440 = 4'h3;
  localparam logic [7:0] BLOCKS_288  = 8'h04;
  localparam logic [7:0] BLOCKS_1440 = 8'h14;

  localparam logic [3:0] PAYLOAD_BYTES       = 4'h9;
  localparam logic [3:0] PAYLOAD_BYTES_TYPE2 = 4'h5;

  // Over-air and uncoded bit counts per block kind
  localparam logic [7:0] AIR_HEADER   = 8'd120;
  localparam logic [7:0] AIR_BLOCK    = 8'd72;
  localparam logic [7:0] AIR_END      = 8'd36;
  localparam logic [7:0] RAW_HEADER   = 8'd72;
  localparam logic [7:0] RAW_PAYLOAD  = 8'd72;
  localparam logic [7:0] RAW_TYPE2    = 8'd40;
  localparam logic [7:0] RAW_BEACON   = 8'd17;
  localparam logic [7:0] RAW_CONTROL  = 8'd41;
  localparam logic [7:0] RAW_END      = 8'd17;

  localparam logic [15:0] RESET_WORD = 16'h0000;

  typedef enum logic [1:0] {
    BLK_HEADER  = 2'h0,
    BLK_PAYLOAD = 2'h1,
    BLK_CONTROL = 2'h2,
    BLK_END     = 2'h3
  } baf_kind_type;

  typedef struct packed {
    logic [WORD_W-1:0] w4;
    logic [WORD_W-1:0] w3;
    logic [WORD_W-1:0] w2;
    logic [WORD_W-1:0] w1;
    logic [WORD_W-1:0] w0;
  } baf_block_type;

  typedef struct packed {
    logic [7:0] over_air;
    logic [7:0] uncoded;
  } baf_size_type;

  // Binary to eight BCD digits by shift and add-three
  function automatic logic [BCD_W-1:0] baf_to_bcd(input logic [ID_W-1:0] bin);
    logic [BCD_W-1:0] bcd;
    bcd = '0;
    for (int i = ID_W - 1; i >= 0; i--) begin
      for (int d = 0; d < 8; d++) begin
        if (bcd[4*d +: 4] > 4'h4) begin
          bcd[4*d +: 4] = bcd[4*d +: 4] + 4'h3;
        end
      end
      bcd = {bcd[BCD_W-2:0], bin[i]};
    end
    return bcd;
  endfunction : baf_to_bcd

  function automatic baf_size_type baf_block_size(input logic [1:0] kind,
                                                   input logic       beacon,
                                                   input logic       type2);
    baf_size_type s;
    s.over_air = AIR_BLOCK;
    s.uncoded  = RAW_PAYLOAD;
    unique case (kind)
      BLK_HEADER: begin
        s.over_air = AIR_HEADER;
        s.uncoded  = RAW_HEADER;
      end
      BLK_PAYLOAD: s.uncoded = beacon ? RAW_BEACON : (type2 ? RAW_TYPE2 : RAW_PAYLOAD);
      BLK_CONTROL: s.uncoded = RAW_CONTROL;
      BLK_END: begin
        s.over_air = AIR_END;
        s.uncoded  = RAW_END;
      end
    endcase
    return s;
  endfunction : baf_block_size

endpackage : baf_pkg

//--- test/baf_framer_monitor.sv
// Purpose: Concurrent checks on the framer transmit and receive ports
// Assumes: One clock domain, reset_n active low
// Notes:   Sees the top module ports only
`timescale 1ns/100ps
module baf_framer_monitor
  import baf_pkg::*;
#(
  parameter logic [SYNC_W-1:0] NORMAL_SYNC = 24'h0000_00
)
(
  // Clock, reset and inputs
  input wire logic              clock,
  input wire logic              reset_n,
  input wire logic              host_write,
  input wire logic [2:0]        host_write_index,
  input wire logic [WORD_W-1:0] host_write_data,
  input wire logic              payload_type2,
  input wire logic              rx_sync_valid,
  input wire logic [SYNC_W-1:0] rx_sync_word,
  input wire logic              rx_block_valid,
  // Outputs
  input wire logic              beacon_channel,
  input wire logic              tx_block_valid,
  input wire baf_block_type     tx_block,
  input wire baf_size_type      tx_block_size,
  input wire logic              tx_sequence_error,
  input wire logic              tx_size_error,
  input wire logic              packet_burst,
  input wire logic              rx_data_ready,
  input wire logic              rx_burst_rejected
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire logic [1:0] tx_kind    = tx_block.w0[5:4];
  wire logic [1:0] tx_count   = tx_block.w0[7:6];
  wire logic [3:0] want_bytes = payload_type2 ? PAYLOAD_BYTES_TYPE2 : PAYLOAD_BYTES;
  wire logic       inv_sync   = rx_sync_word == ~NORMAL_SYNC;
  // Stored count equals the snapshot count, so the snapshot stands in for it
  wire logic       new_count  = host_write && host_write_index == 3'h0
                                && host_write_data[7:6] != tx_count;
  ////////////////////////////////////////////////////////////////////////
  property p_tx_announce; new_count |=> tx_block_valid; endproperty
  a_tx_announce: assert property (p_tx_announce) else $error("no block on count change");
  property p_tx_cause;
    tx_block_valid |-> $past(new_count) && tx_block.w0 == $past(host_write_data);
  endproperty
  a_tx_cause: assert property (p_tx_cause) else $error("block without count change");
  property p_tx_seq;
    tx_block_valid |-> tx_sequence_error == (tx_count != 2'($past(tx_count) + 2'h1));
  endproperty
  a_tx_seq: assert property (p_tx_seq) else $error("sequence flag wrong");
  property p_tx_flags; tx_sequence_error || tx_size_error |-> tx_block_valid; endproperty
  a_tx_flags: assert property (p_tx_flags) else $error("error flag without block");
  property p_tx_size;
    tx_block_valid && !beacon_channel
      |-> tx_size_error == (tx_kind == BLK_PAYLOAD && tx_block.w0[3:0] != $past(want_bytes));
  endproperty
  a_tx_size: assert property (p_tx_size) else $error("size flag wrong");
  property p_tx_air;
    tx_block_valid |-> tx_block_size.over_air ==
      (tx_kind == BLK_HEADER ? AIR_HEADER : (tx_kind == BLK_END ? AIR_END : AIR_BLOCK));
  endproperty
  a_tx_air: assert property (p_tx_air) else $error("over-air size wrong");
  property p_rx_cause;
    rx_data_ready || rx_burst_rejected |-> $past(rx_block_valid) && !$past(rx_sync_valid)
      && !(rx_data_ready && rx_burst_rejected);
  endproperty
  a_rx_cause: assert property (p_rx_cause) else $error("receive pulse without block");
  property p_sync;
    rx_sync_valid && (rx_sync_word == NORMAL_SYNC || inv_sync) |=> packet_burst == $past(inv_sync);
  endproperty
  a_sync: assert property (p_sync) else $error("packet marker wrong after sync");
  cover property (tx_block_valid && tx_sequence_error);
  cover property (rx_burst_rejected);
  cover property (rx_data_ready && packet_burst);
endmodule : baf_framer_monitor

bind baf_burst_framer baf_framer_monitor #(.NORMAL_SYNC(NORMAL_SYNC)) baf_framer_monitor_inst (
  .clock(clock), .reset_n(reset_n), .host_write(host_write),
  .host_write_index(host_write_index), .host_write_data(host_write_data),
  .payload_type2(payload_type2), .rx_sync_valid(rx_sync_valid), .rx_sync_word(rx_sync_word),
  .rx_block_valid(rx_block_valid), .beacon_channel(beacon_channel),
  .tx_block_valid(tx_block_valid), .tx_block(tx_block), .tx_block_size(tx_block_size),
  .tx_sequence_error(tx_sequence_error), .tx_size_error(tx_size_error),
  .packet_burst(packet_burst), .rx_data_ready(rx_data_ready),
  .rx_burst_rejected(rx_burst_rejected));

//--- test/baf_host_model.sv
// Purpose: Host that moves blocks through the transmit words and reads words back
// Assumes: Requests change one time unit after the rising edge
// Notes:   Word zero goes last; the count change announces the block
`timescale 1ns/100ps
module baf_host_model
  import baf_pkg::*;
(
  // Clock
  input  wire logic              clock,
  // Host data word port
  output logic                   host_write,
  output logic [2:0]             host_write_index,
  output logic [WORD_W-1:0]      host_write_data,
  output logic                   host_read_rx,
  output logic [2:0]             host_read_index,
  input  wire logic [WORD_W-1:0] host_read_data
);
  logic [1:0] tx_count = 2'h0;
  initial begin
    host_write = 1'b0;
    host_write_index = 3'h0;
    host_write_data = 16'h0000;
    host_read_rx = 1'b0;
    host_read_index = 3'h0;
  end
  ////////////////////////////////////////
  task write_word(input logic [2:0] idx, input logic [WORD_W-1:0] d);
    @(posedge clock);
    #1;
    host_write = 1'b1;
    host_write_index = idx;
    host_write_data = d;
    @(posedge clock);
    #1;
    host_write = 1'b0;
    host_write_data = ~d;
  endtask : write_word
  // Step other than one models a lost or repeated block
  task send_block(input logic [1:0] kind, input logic [3:0] bytes, input logic [1:0] step);
    for (int i = 1; i < 5; i++) begin
      write_word(i[2:0], 16'h1111 * i[15:0]);
    end
    tx_count = tx_count + step;
    write_word(3'h0, {8'hA5, tx_count, kind, bytes});
  endtask : send_block
  task read_word(input logic rx, input logic [2:0] idx, output logic [WORD_W-1:0] d);
    @(posedge clock);
    #1;
    host_read_rx = rx;
    host_read_index = idx;
    @(posedge clock);
    #1;
    d = host_read_data;
  endtask : read_word
endmodule : baf_host_model

//--- test/testbench.sv
// Purpose: Self-checking bench for the burst framer
// Assumes: Host model drives the word port; bench drives the demodulator side
// Notes:   Wildcard ids read the same under either prefix alignment
`timescale 1ns/100ps
module testbench
  import baf_pkg::*;
;
  localparam logic [SYNC_W-1:0] SYNC = 24'h5A3C_96;
  localparam baf_block_type BLK = 80'h4444_3333_2222_1111_0009;
  localparam logic [15:0] SIZES [4] = '{16'h7848, 16'h4848, 16'h4829, 16'h2411};
  logic clock = 1'b0, reset_n = 1'b0, payload_type2 = 1'b0;
  logic rx_sync_valid = 1'b0, rx_block_valid = 1'b0;
  logic [WORD_W-1:0] modem_config = 16'h0400, rd, rd0;
  logic [ID_W-1:0] id_a = 24'h12_3456, id_b = 24'h00_ABCD;
  logic [SYNC_W-1:0] rx_sync_word = 24'h0000_00;
  logic [1:0] rx_block_kind = 2'h0;
  baf_block_type rx_block = BLK;
  wire logic host_write, host_read_rx, rx_data_ready, rx_burst_rejected, packet_burst;
  wire logic tx_block_valid, tx_sequence_error, tx_size_error, beacon_channel;
  wire logic [2:0] host_write_index, host_read_index;
  wire logic [WORD_W-1:0] host_write_data, host_read_data;
  wire baf_size_type rx_block_size, tx_block_size;
  wire baf_block_type tx_block;
  int fail_count = 0, n_checks = 0, cycles = 0;

  baf_burst_framer #(.NORMAL_SYNC(SYNC)) baf_burst_framer_inst (
    .clock(clock), .reset_n(reset_n), .modem_config(modem_config),
    .local_identity_a(id_a), .local_identity_b(id_b), .payload_type2(payload_type2),
    .host_write(host_write), .host_write_index(host_write_index),
    .host_write_data(host_write_data), .host_read_rx(host_read_rx),
    .host_read_index(host_read_index), .host_read_data(host_read_data),
    .rx_sync_valid(rx_sync_valid), .rx_sync_word(rx_sync_word),
    .rx_block_valid(rx_block_valid), .rx_block_kind(rx_block_kind), .rx_block(rx_block),
    .rx_data_ready(rx_data_ready), .rx_burst_rejected(rx_burst_rejected),
    .packet_burst(packet_burst), .rx_block_size(rx_block_size),
    .tx_block_valid(tx_block_valid), .tx_block(tx_block), .tx_block_size(tx_block_size),
    .tx_sequence_error(tx_sequence_error), .tx_size_error(tx_size_error),
    .beacon_channel(beacon_channel));
  baf_host_model baf_host_model_inst (
    .clock(clock), .host_write(host_write), .host_write_index(host_write_index),
    .host_write_data(host_write_data), .host_read_rx(host_read_rx),
    .host_read_index(host_read_index), .host_read_data(host_read_data));

  always #5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      results();
    end
  end
  ////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task results();
    $display("comparisons %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  function automatic baf_block_type hdr(input logic [ID_W-1:0] d, input logic [1:0] f = 2'h0,
                                        input logic [3:0] len = 4'h0);
    hdr.w0 = {4'h0, d[23:20], 8'h09};
    hdr.w1 = d[19:4];
    hdr.w2 = {d[3:0], 12'h000};
    hdr.w3 = 16'h0008;
    hdr.w4 = {1'h0, f, 5'h03, len, 4'h0};
  endfunction : hdr
  // Released block and sync word lines show the inverse so a stale value cannot pass
  task rx_pulse(input logic s, input logic [1:0] k, input baf_block_type b);
    @(posedge clock);
    #1;
    rx_sync_valid = s;
    rx_block_valid = !s;
    rx_sync_word = b[SYNC_W-1:0];
    rx_block_kind = k;
    rx_block = b;
    @(posedge clock);
    #1;
    rx_sync_valid = 1'b0;
    rx_block_valid = 1'b0;
    rx_block = ~b;
    rx_sync_word = ~b[SYNC_W-1:0];
  endtask : rx_pulse
  task block(input logic [1:0] k, input logic r);
    rx_pulse(1'b0, k, BLK);
    check(rx_data_ready, r);
  endtask : block
  task burst(input logic [SYNC_W-1:0] w, input baf_block_type h, input logic [1:0] exp);
    rx_pulse(1'b1, 2'h0, {56'h0, w});
    rx_pulse(1'b0, 2'h0, h);
    check({rx_data_ready, rx_burst_rejected}, exp);
  endtask : burst
  ////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clock);
    #1;
    reset_n = 1'b1;
    for (int k = 0; k < 4; k++) begin
      baf_host_model_inst.send_block(k[1:0], 4'h9, 2'h1);
      check({tx_block_valid, tx_sequence_error, tx_size_error}, 3'h4);
      check(tx_block.w0, {8'hA5, 2'(k[1:0] + 2'h1), k[1:0], 4'h9});
      check(tx_block_size, SIZES[k]);
    end
    check(tx_block.w1, 16'h1111);
    baf_host_model_inst.send_block(2'h1, 4'h8, 2'h1);
    check(tx_size_error, 1'b1);
    payload_type2 = 1'b1;
    baf_host_model_inst.send_block(2'h1, 4'h5, 2'h1);
    check({tx_size_error, tx_block_size}, 17'h0_4828);
    baf_host_model_inst.send_block(2'h1, 4'h5, 2'h2);
    check({tx_block_valid, tx_sequence_error}, 2'h3);
    baf_host_model_inst.send_block(2'h1, 4'h5, 2'h0);
    check(tx_block_valid, 1'b0);
    modem_config = 16'h1400;
    baf_host_model_inst.send_block(2'h1, 4'h3, 2'h1);
    check({beacon_channel, tx_size_error, tx_block_size}, 18'h2_4811);
    baf_host_model_inst.read_word(1'b0, 3'h2, rd);
    check(rd, 16'h2222);
    baf_host_model_inst.read_word(1'b0, 3'h5, rd);
    check(rd, 16'h0000);
    modem_config = 16'h0400;
    payload_type2 = 1'b0;
    burst(SYNC, hdr(id_a), 2'h2);
    check(packet_burst, 1'b0);
    baf_host_model_inst.read_word(1'b1, 3'h0, rd0);
    block(2'h1, 1'b1);
    check(rx_block_size, 16'h4848);
    baf_host_model_inst.read_word(1'b1, 3'h0, rd);
    check({rd0[5:0], rd[5:0], rd[7:6]}, {12'h259, 2'(rd0[7:6] + 2'h1)});
    block(2'h3, 1'b1);
    check(rx_block_size, 16'h2411);
    block(2'h1, 1'b0);
    burst(SYNC, hdr(24'h11_1111), 2'h1);
    block(2'h1, 1'b0);
    burst(SYNC, hdr(24'h11_1111, FORMAT_CALL_ALL), 2'h2);
    burst(SYNC, hdr(id_b), 2'h2);
    modem_config = 16'h0000;
    burst(SYNC, hdr(24'h11_1111), 2'h2);
    modem_config = 16'h0C00;
    burst(SYNC, hdr(id_a), 2'h2);
    burst(SYNC, hdr(24'hD7_70CF), 2'h2);
    burst(SYNC, hdr(24'hD9_1EED), 2'h1);
    modem_config = 16'h0400;
    burst(~SYNC, hdr(id_a, FORMAT_PEER, 4'h1), 2'h1);
    check(packet_burst, 1'b1);
    burst(~SYNC, hdr(id_a), 2'h2);
    for (int i = 0; i < 5; i++) begin
      block(2'h1, i < 4);
    end
    burst(~SYNC, hdr(id_a, FORMAT_PEER, 4'h3), 2'h2);
    burst(SYNC, hdr(id_a), 2'h2);
    check(packet_burst, 1'b0);
    results();
  end
endmodule : testbench
